/* verilog/usb_supply_guard_defines.svh */
// Constants for the USB supply guard controller: timing, map and fields.
`ifndef USB_SUPPLY_GUARD_DEFINES_SVH
`define USB_SUPPLY_GUARD_DEFINES_SVH

`define CLK_MHZ          25
`define ON_DELAY_US      17000
`define REC_DELAY_US     8000
`define OV_FILT_US       11
`define TMR_W            19
`define ACC_W            9

`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_IRQ_STAT    8'h08
`define ADDR_IRQ_MASK    8'h0C

`define CTRL_BLOCK_BIT   0
`define CTRL_RESET       1'b0
`define MASK_RESET       4'h0
`define IRQ_UV_BIT       0
`define IRQ_OV_BIT       1
`define IRQ_OT_BIT       2
`define IRQ_ON_BIT       3
`define IRQ_W            4

`endif

/* verilog/usb_supply_guard_pkg.sv */
// Types shared by the USB supply guard controller.
`default_nettype none
package usb_supply_guard_pkg;

	typedef struct packed {
		logic       uv;
		logic [1:0] ov_code;
		logic       ot;
		logic       en_n;
	} guard_flags_t;

	typedef enum logic [1:0] {
		ST_LOCK,
		ST_DELAY,
		ST_READY
	} guard_state_t;

endpackage : usb_supply_guard_pkg
`default_nettype wire

/* verilog/usb_supply_guard_controller.sv */
// USB supply guard controller with sequencing and an AHB-Lite register slave.
// Functional notes
// - Lockout at any time opens switch, stops pump.
// - Any fault releases the status output.
// - Overvoltage recovery closes switch after 8 ms.
// - Power-up and undervoltage recovery wait 17 ms.
// - Status driven low again when switch closes.
// - Lockout stops the delay timer and holds it at zero.
// - Pump enabled only after timer expiry.
// - Supply must stay valid the whole delay.
// - Integrating filter delays overvoltage turn-off.
// - Status is open-drain, low only when healthy.
// - Over-temperature opens switch until flag clears.
// - Flags or the CTRL block bit force off; else switch follows enable.
// - Turn-on delay lies within 16 to 22 ms.
// - Overvoltage recovery stays at most 10.5 ms.
`timescale 1ns/1ns
`default_nettype none
`include "usb_supply_guard_defines.svh"

module usb_supply_guard_controller
	import usb_supply_guard_pkg::*;
#(
	parameter logic [`TMR_W-1:0] ON_DELAY_CYC =
		`TMR_W'(`ON_DELAY_US * `CLK_MHZ),
	parameter logic [`TMR_W-1:0] REC_DELAY_CYC =
		`TMR_W'(`REC_DELAY_US * `CLK_MHZ)
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        uv_flag_in,
	input  wire logic [1:0]  ov_excursion_in,
	input  wire logic        ot_flag_in,
	input  wire logic        switch_enable_n_in,
	output var  logic        load_switch_out,
	output var  logic        charge_pump_enable_out,
	output var  logic        supply_ok_n_out,
	output var  logic        supply_ok_n_oe_out,
	output var  logic        irq_out,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output var  logic        hreadyout_out,
	output var  logic        hresp_out,
	output var  logic [31:0] hrdata_out
);

	localparam logic [`ACC_W-1:0] OV_TRIP =
		`ACC_W'(`OV_FILT_US * `CLK_MHZ);

	guard_flags_t            raw_flags;
	guard_flags_t            sync1_q;
	guard_flags_t            flg;
	guard_state_t            st_q;
	guard_state_t            st_d;
	logic [`TMR_W-1:0]       tmr_q;
	logic [`TMR_W-1:0]       tmr_d;
	logic [`TMR_W-1:0]       lim;
	logic [`ACC_W-1:0]       acc_q;
	logic [`ACC_W-1:0]       acc_d;
	logic [`ACC_W:0]         acc_sum;
	logic                    ovl_q;
	logic                    ovl_d;
	logic                    ov_kind_q;
	logic                    fault;
	logic                    block_q;
	logic                    switch_d;
	logic                    ok_d;
	logic                    uv_prev_q;
	logic                    ot_prev_q;
	logic [`IRQ_W-1:0]       evt;
	logic [`IRQ_W-1:0]       ists_q;
	logic [`IRQ_W-1:0]       imask_q;
	logic [`IRQ_W-1:0]       w1c;
	logic                    addr_ok;
	logic                    wr_pend_q;
	logic [7:0]              waddr_q;
	logic                    wr_ctrl;
	logic                    wr_ists;
	logic                    wr_imask;
	logic [31:0]             rd_mux;
	logic [31:0]             status_word;

	assign raw_flags = '{uv: uv_flag_in, ov_code: ov_excursion_in,
		ot: ot_flag_in, en_n: switch_enable_n_in};

	// flag synchroniser. The enable resets high, i.e. switch disallowed.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= '{uv: 1'b1, ov_code: 2'h0, ot: 1'b0, en_n: 1'b1};
			flg     <= '{uv: 1'b1, ov_code: 2'h0, ot: 1'b0, en_n: 1'b1};
		end else begin
			sync1_q <= raw_flags;
			flg     <= sync1_q;
		end
	end

	// turn-off integrator. Bigger excursion codes fill it faster.
	assign acc_sum = {1'b0, acc_q} + {{(`ACC_W-1){1'b0}}, flg.ov_code};
	assign ovl_d   = ovl_q ? (flg.ov_code != 2'h0)
		: ({1'b0, OV_TRIP} <= acc_sum);
	assign acc_d   = (flg.ov_code == 2'h0)
		? ((acc_q == '0) ? acc_q : acc_q - `ACC_W'(1))
		: (ovl_d ? OV_TRIP : acc_sum[`ACC_W-1:0]);

	assign fault = flg.uv | ovl_q;

	// recovery delay chosen by the cause of the last lockout.
	assign lim = ov_kind_q ? REC_DELAY_CYC : ON_DELAY_CYC;

	// timer runs only with no lockout and restarts on any glitch.
	assign tmr_d = (st_q == ST_DELAY && !fault) ? tmr_q + `TMR_W'(1)
		: '0;

	always_comb begin
		st_d = st_q;
		if (fault) begin
			st_d = ST_LOCK;
		end else begin
			unique case (st_q)
				ST_LOCK:  st_d = ST_DELAY;
				ST_DELAY: st_d = (tmr_q == lim - `TMR_W'(1))
					? ST_READY : ST_DELAY;
				ST_READY: st_d = ST_READY;
			endcase
		end
	end

	assign switch_d = (st_d == ST_READY) && !fault && !flg.ot && !flg.en_n
		&& !block_q;
	// status pulled low only when healthy.
	assign ok_d = (st_d == ST_READY) && !fault && !flg.ot;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q      <= ST_LOCK;
			tmr_q     <= '0;
			acc_q     <= '0;
			ovl_q     <= 1'b0;
			ov_kind_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			tmr_q     <= tmr_d;
			acc_q     <= acc_d;
			ovl_q     <= ovl_d;
			ov_kind_q <= flg.uv ? 1'b0 : (ovl_q ? 1'b1 : ov_kind_q);
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			load_switch_out        <= 1'b0;
			charge_pump_enable_out <= 1'b0;
			supply_ok_n_out        <= 1'b0;
			supply_ok_n_oe_out     <= 1'b0;
		end else begin
			load_switch_out        <= switch_d;
			charge_pump_enable_out <= switch_d;
			supply_ok_n_out        <= 1'b0;
			supply_ok_n_oe_out     <= ok_d;
		end
	end

	// Interrupt events: lockout entries, over-temperature, switch closing.
	assign evt[`IRQ_UV_BIT] = flg.uv & !uv_prev_q;
	assign evt[`IRQ_OV_BIT] = ovl_d & !ovl_q;
	assign evt[`IRQ_OT_BIT] = flg.ot & !ot_prev_q;
	assign evt[`IRQ_ON_BIT] = switch_d & !load_switch_out;

	// AHB-Lite decode; the slave is always ready and always answers OKAY.
	assign addr_ok  = hsel_in && htrans_in[1] && hready_in;
	assign wr_ctrl  = wr_pend_q && (waddr_q == `ADDR_CTRL);
	assign wr_ists  = wr_pend_q && (waddr_q == `ADDR_IRQ_STAT);
	assign wr_imask = wr_pend_q && (waddr_q == `ADDR_IRQ_MASK);
	assign w1c      = wr_ists ? hwdata_in[`IRQ_W-1:0] : '0;

	assign status_word = {24'h0, ov_kind_q, st_q == ST_READY,
		load_switch_out, supply_ok_n_oe_out, flg.en_n, flg.ot, ovl_q,
		flg.uv};
	assign rd_mux =
		(haddr_in[7:0] == `ADDR_CTRL)     ? {31'h0, block_q} :
		(haddr_in[7:0] == `ADDR_STATUS)   ? status_word :
		(haddr_in[7:0] == `ADDR_IRQ_STAT) ? {28'h0, ists_q} :
		(haddr_in[7:0] == `ADDR_IRQ_MASK) ? {28'h0, imask_q} : 32'h0;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_pend_q     <= 1'b0;
			waddr_q       <= 8'h00;
			hrdata_out    <= 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			wr_pend_q     <= addr_ok && hwrite_in
				&& (haddr_in[31:8] == 24'h0);
			waddr_q       <= haddr_in[7:0];
			hrdata_out    <= (addr_ok && !hwrite_in
				&& haddr_in[31:8] == 24'h0) ? rd_mux : 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	// Set wins over a simultaneous write-one-to-clear.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			block_q   <= `CTRL_RESET;
			imask_q   <= `MASK_RESET;
			ists_q    <= '0;
			uv_prev_q <= 1'b1;
			ot_prev_q <= 1'b0;
			irq_out   <= 1'b0;
		end else begin
			block_q   <= wr_ctrl ? hwdata_in[`CTRL_BLOCK_BIT] : block_q;
			imask_q   <= wr_imask ? hwdata_in[`IRQ_W-1:0] : imask_q;
			ists_q    <= (ists_q & ~w1c) | evt;
			uv_prev_q <= flg.uv;
			ot_prev_q <= flg.ot;
			irq_out   <= |(ists_q & imask_q);
		end
	end

	a_fault_opens_switch: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) fault |=> !load_switch_out
		&& !charge_pump_enable_out)
		else $error("switch or pump on after a lockout");

	a_fault_rel_ok: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) fault |=> !supply_ok_n_oe_out)
		else $error("status still pulled low during a fault");

	a_ov_rec_len: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (st_q == ST_DELAY && ov_kind_q && !fault
		&& tmr_q == REC_DELAY_CYC - `TMR_W'(1)) |=> st_q == ST_READY)
		else $error("overvoltage recovery uses wrong delay");

	a_delay_end: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (st_q == ST_DELAY && !ov_kind_q && !fault
		&& tmr_q == ON_DELAY_CYC - `TMR_W'(1)) |=> st_q == ST_READY)
		else $error("turn-on delay ended at wrong count");

	a_timer_frozen: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) fault |=> tmr_q == '0 [*2])
		else $error("timer ran during lockout");

	a_pump_after: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) $rose(charge_pump_enable_out)
		|-> $past(st_d) == ST_READY && st_q == ST_READY)
		else $error("pump enabled before timer expiry");

	a_glitch_reject: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (!ovl_q && acc_q < OV_TRIP - `ACC_W'(3))
		|=> !ovl_q)
		else $error("overvoltage tripped before integrator filled");

	a_ot_opens: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) flg.ot |=> !load_switch_out
		&& !supply_ok_n_oe_out)
		else $error("switch closed during over-temperature");

	a_sw_follow: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (st_d == ST_READY && !fault && !flg.ot
		&& !block_q) |=> load_switch_out == !$past(flg.en_n)
		&& supply_ok_n_oe_out)
		else $error("switch does not follow enable");

	a_irq_level: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) |(ists_q & imask_q) |=> irq_out)
		else $error("interrupt missing for unmasked status");

	a_status_on_close: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) $rose(load_switch_out) |-> supply_ok_n_oe_out)
		else $error("switch closed without status pulled low");

	a_ok_when_healthy: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) supply_ok_n_oe_out |-> !supply_ok_n_out
		&& !$past(fault) && !$past(flg.ot))
		else $error("status pulled low while not healthy");

	// The slave never stalls and always answers OKAY.
	a_bus_okay: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) hreadyout_out && !hresp_out)
		else $error("bus slave stalled or signalled an error");

endmodule : usb_supply_guard_controller
`default_nettype wire

/* test/usb_supply_guard_host.sv */
// Host model: drives the enable pin and reads the pulled-up status wire.
`timescale 1ns/1ns
`default_nettype none
module usb_supply_guard_host (
	input  wire logic clk_in,
	input  wire logic want_on_in,
	input  wire logic ok_data_in,
	input  wire logic ok_oe_in,
	output var  logic switch_enable_n_out,
	output wire logic status_n_out
);
	always_ff @(posedge clk_in) begin
		switch_enable_n_out <= ~want_on_in;
	end
	assign status_n_out = ok_oe_in ? ok_data_in : 1'b1;
endmodule : usb_supply_guard_host
`default_nettype wire

/* test/usb_supply_guard_controller_tb_top.sv */
// Self-checking bench for the USB supply guard controller.
`timescale 1ns/1ns
`default_nettype none
module usb_supply_guard_controller_tb_top;
	import usb_supply_guard_pkg::*;
	localparam int ON = 40;
	localparam int REC = 20;
	logic        sys_clk_in = 0;
	logic        rst_in = 1;
	logic        uv = 1;
	logic [1:0]  ov = 0;
	logic        ot = 0;
	logic        want_on = 1;
	logic        en_n, switch_on, pump_on, ok_d, ok_oe, irq, st_n;
	logic        hrdy, hresp;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	int          n_fail = 0;
	int          samples_checked = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	usb_supply_guard_controller #(.ON_DELAY_CYC(19'(ON)),
		.REC_DELAY_CYC(19'(REC))) usb_supply_guard_controller_i (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .uv_flag_in(uv),
		.ov_excursion_in(ov), .ot_flag_in(ot), .switch_enable_n_in(en_n),
		.load_switch_out(switch_on), .charge_pump_enable_out(pump_on),
		.supply_ok_n_out(ok_d), .supply_ok_n_oe_out(ok_oe), .irq_out(irq),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
		.hrdata_out(hrdata));
	usb_supply_guard_host usb_supply_guard_host_i (.clk_in(sys_clk_in),
		.want_on_in(want_on), .ok_data_in(ok_d), .ok_oe_in(ok_oe),
		.switch_enable_n_out(en_n), .status_n_out(st_n));
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			$display("BAD %s expected %0h seen %0h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : tick
	task automatic wait_switch(input logic v, output int n);
		n = 0;
		while (switch_on !== v && n < 2000) begin
			tick(1);
			n++;
		end
	endtask : wait_switch
	task automatic ahb(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		@(posedge sys_clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge sys_clk_in); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk_in); while (hrdy !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic t_powerup();
		int n;
		@(posedge sys_clk_in);
		uv <= 1'b0;
		wait_switch(1'b1, n);
		chk("on_delay", 1, n >= ON && n <= ON + 8);
		chk("pump_on", 1, pump_on);
		chk("status_low", 0, st_n);
	endtask : t_powerup
	task automatic t_uv();
		int n;
		@(posedge sys_clk_in);
		uv <= 1'b1;
		tick(4);
		chk("uv_switch", 0, switch_on);
		chk("uv_pump", 0, pump_on);
		chk("uv_status", 1, st_n);
		@(posedge sys_clk_in);
		uv <= 1'b0;
		tick(ON / 2);
		@(posedge sys_clk_in);
		uv <= 1'b1;
		tick(ON);
		chk("glitch_switch", 0, switch_on);
		@(posedge sys_clk_in);
		uv <= 1'b0;
		wait_switch(1'b1, n);
		chk("uv_recover", 1, n >= ON && n <= ON + 8);
	endtask : t_uv
	task automatic t_ov();
		int n;
		@(posedge sys_clk_in);
		ov <= 2'h2;
		tick(100);
		chk("ov_small", 1, switch_on);
		@(posedge sys_clk_in);
		ov <= 2'h0;
		tick(250);
		@(posedge sys_clk_in);
		ov <= 2'h3;
		wait_switch(1'b0, n);
		chk("ov_trip", 1, n >= 85 && n <= 100);
		chk("ov_status", 1, st_n);
		chk("ov_pump", 0, pump_on);
		tick(30);
		@(posedge sys_clk_in);
		ov <= 2'h0;
		wait_switch(1'b1, n);
		chk("ov_recover", 1, n >= REC && n <= REC + 8);
		chk("ov_status_low", 0, st_n);
	endtask : t_ov
	task automatic t_ot();
		@(posedge sys_clk_in);
		ot <= 1'b1;
		tick(4);
		chk("ot_switch", 0, switch_on);
		chk("ot_status", 1, st_n);
		@(posedge sys_clk_in);
		ot <= 1'b0;
		tick(4);
		chk("ot_back", 1, switch_on);
		chk("ot_status_low", 0, st_n);
	endtask : t_ot
	task automatic t_enable();
		@(posedge sys_clk_in);
		want_on <= 1'b0;
		tick(5);
		chk("en_off", 0, switch_on);
		chk("en_status", 0, st_n);
		@(posedge sys_clk_in);
		want_on <= 1'b1;
		tick(5);
		chk("en_on", 1, switch_on);
	endtask : t_enable
	task automatic t_regs();
		logic [31:0] r;
		ahb(1'b0, 32'h0000_000C, 32'h0, r);
		chk("mask_reset", 0, r);
		chk("bus_okay", 0, hresp);
		chk("irq_masked", 0, irq);
		ahb(1'b1, 32'h0000_000C, 32'h0000_0001, r);
		tick(2);
		chk("irq_raised", 1, irq);
		ahb(1'b1, 32'h0000_0008, 32'h0000_0001, r);
		tick(2);
		chk("irq_cleared", 0, irq);
		ahb(1'b0, 32'h0000_0004, 32'h0, r);
		chk("status_reg", 32'h0000_0070, r & 32'h0000_007F);
		ahb(1'b0, 32'h0000_0100, 32'h0, r);
		chk("unmapped", 0, r);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0001, r);
		tick(5);
		chk("block_off", 0, switch_on);
		ahb(1'b1, 32'h0000_0000, 32'h0, r);
		tick(5);
		chk("unblock_on", 1, switch_on);
	endtask : t_regs
	task automatic final_report();
		$display("Checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_powerup();
		t_uv();
		t_ov();
		t_ot();
		t_enable();
		t_regs();
		final_report();
	end
	initial begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule : usb_supply_guard_controller_tb_top
`default_nettype wire
